// >>> cpad_pkg.sv
// package: constants and types for the configuration port access decoder
package cpad_pkg;

  // key bytes written to the key-entry port
  localparam logic [7:0]  KEY_ENTER     = 8'h55;
  localparam logic [7:0]  KEY_EXIT      = 8'hAA;

  // key-entry port base selected by the strap pin
  localparam logic [11:0] BASE_STRAP_LO = 12'h02E;
  localparam logic [11:0] BASE_STRAP_HI = 12'h04E;
  localparam int          BASE_W        = 12;

  // hard reset values of the two base-address registers
  localparam logic [7:0]  BASE_LOW_RST0 = 8'h2E;
  localparam logic [7:0]  BASE_LOW_RST1 = 8'h4E;
  localparam logic [7:0]  BASE_HIGH_RST = 8'h00;

  // writable bits of the base-address registers
  localparam logic [7:0]  BASE_LOW_MASK  = 8'hFE;
  localparam logic [7:0]  BASE_HIGH_MASK = 8'h0F;

  // value port offset from the key-entry port
  localparam logic [15:0] VALUE_PORT_OFS = 16'h0001;

  // global configuration register indexes and the first logical-device index
  localparam logic [7:0]  IDX_CFG_CTRL  = 8'h02;
  localparam logic [7:0]  IDX_LDN       = 8'h07;
  localparam logic [7:0]  IDX_DEV_ID    = 8'h20;
  localparam logic [7:0]  IDX_DEV_REV   = 8'h21;
  localparam logic [7:0]  IDX_BASE_LOW  = 8'h26;
  localparam logic [7:0]  IDX_BASE_HIGH = 8'h27;
  localparam logic [7:0]  IDX_LD_FIRST  = 8'h30;

  // bit positions and reset values
  localparam int          SOFT_RST_BIT  = 0;
  localparam logic [7:0]  LDN_RST       = 8'h00;
  localparam logic [7:0]  PTR_RST       = 8'h00;
  localparam logic [7:0]  KEY_READ_NONE = 8'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // operating states
  typedef enum logic {
    ST_RUN,
    ST_CONFIG
  } cpad_state_t;

endpackage : cpad_pkg

// >>> cpad_cfg_if.sv
// interface: base-register and storage links inside the decoder
`timescale 1ns/1ps
`default_nettype none
interface cpad_cfg_if #(
  parameter int ADDR_W = 12
);
  // base-address register group
  logic              strap;
  logic              hardLoad;
  logic              wrLow;
  logic              wrHigh;
  logic [7:0]        wdata;
  logic [7:0]        baseLow;
  logic [7:0]        baseHigh;
  logic [11:0]       decodeBase;
  // logical-device storage group
  logic [ADDR_W-1:0] memAddr;
  logic              memWe;
  logic [7:0]        memRdata;

  modport ctl  (output strap, hardLoad, wrLow, wrHigh, wdata, memAddr,
                memWe, input baseLow, baseHigh, decodeBase, memRdata);
  modport base (input strap, hardLoad, wrLow, wrHigh, wdata,
                output baseLow, baseHigh, decodeBase);
  modport mem  (input memAddr, memWe, wdata, output memRdata);
endinterface : cpad_cfg_if
`default_nettype wire

// >>> cpad_base_regs.sv
// base-address registers and the live port decode base
`timescale 1ns/1ps
`default_nettype none
module cpad_base_regs
  import cpad_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstN,
  input  wire logic ce,
  // register link
  cpad_cfg_if.base  cfg
);

  logic [7:0]        low_q,  low_d;
  logic [7:0]        high_q, high_d;
  logic [BASE_W-1:0] dec_q,  dec_d;

  // next values; hard load takes priority over host writes
  always_comb
  begin
    low_d  = low_q;
    high_d = high_q;
    dec_d  = dec_q;
    if (cfg.hardLoad)
    begin
      low_d  = cfg.strap ? BASE_LOW_RST1 : BASE_LOW_RST0;
      high_d = BASE_HIGH_RST;
      dec_d  = cfg.strap ? BASE_STRAP_HI : BASE_STRAP_LO;
    end
    else if (cfg.wrLow)
      low_d  = cfg.wdata & BASE_LOW_MASK;
    else if (cfg.wrHigh)
    begin
      high_d = cfg.wdata & BASE_HIGH_MASK;
      // among host writes decode moves only here, low byte alone never moves it
      dec_d  = {cfg.wdata[3:0], low_q};
    end
  end

  // registers; async value is overwritten by the first hard load
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      low_q  <= BASE_LOW_RST0;
      high_q <= BASE_HIGH_RST;
      dec_q  <= BASE_STRAP_LO;
    end
    else if (ce)
    begin
      low_q  <= low_d;
      high_q <= high_d;
      dec_q  <= dec_d;
    end
  end

  assign cfg.baseLow    = low_q;
  assign cfg.baseHigh   = high_q;
  assign cfg.decodeBase = dec_q;

endmodule : cpad_base_regs
`default_nettype wire

// >>> cpad_ld_mem.sv
// storage for logical-device registers, registered read data
`timescale 1ns/1ps
`default_nettype none
module cpad_ld_mem #(
  parameter int ADDR_W = 12
)(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstN,
  input  wire logic ce,
  // storage link
  cpad_cfg_if.mem   cfg
);

  logic [7:0] store [0:(1<<ADDR_W)-1];
  logic [7:0] rd_q;

  // array carries no reset; its contents belong to the logical devices
  always_ff @(posedge mclk)
  begin
    if (ce && cfg.memWe)
      store[cfg.memAddr] <= cfg.wdata;
  end

  // read data one cycle after the address
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      rd_q <= 8'h00;
    else if (ce)
      rd_q <= store[cfg.memAddr];
  end

  assign cfg.memRdata = rd_q;

endmodule : cpad_ld_mem
`default_nettype wire

// >>> cpad_decoder.sv
// top: key-locked configuration port decoder with relocatable base
//
// How it works
// - strap low gives key port 0x02E, strap high gives 0x04E
// - pointer and value ports are ignored outside configuration state
// - writing 0x55 to the key port enters configuration state
// - writing 0xAA to the key port returns to run state
// - key port read outside configuration state is left undriven
// - after unlock and before another key-port write, key-port reads give 0x00
// - once the pointer is written, key-port reads return its last value
// - index 0x26 holds base low byte, index 0x27 the high bits
// - base is always even; low register bit 0 reads zero
// - base spans 0x0000 to 0x0FFE; high register bits 7..4 read zero
// - power-on reset loads the base from the strap pin
// - decode moves when the high byte is written, not the low byte
// - hard reset sets low byte 0x2E or 0x4E, high byte 0x00
// - soft reset leaves both base registers unchanged
// - power-on reset or system reset output gives a hard reset
// - writing one to control register bit 0 gives a soft reset
// - pointer selects the register reached through the value port
`timescale 1ns/1ps
`default_nettype none
module cpad_decoder
  import cpad_pkg::*;
#(
  parameter int         LDN_W   = 4,
  parameter logic [7:0] DEV_ID  = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_REV = 8'h01  // arbitrary value
)(
  // clock, enable and resets
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        systemResetOutputN,
  // strap pin
  input  wire logic        strapPin,
  // host i/o cycle port
  input  wire logic [15:0] ioAddr,
  input  wire logic [7:0]  ioWrData,
  input  wire logic        ioWrStb,
  input  wire logic        ioRdStb,
  output var  logic [7:0]  ioRdData,
  output var  logic        ioRdValid,
  output var  logic        ioRdDrive,
  // status
  output var  logic        cfgActive
);

  localparam int ADDR_W = LDN_W + 8;

  // ---- reset release and strap capture
  logic [1:0] rstPipe_q;
  logic       rstN;
  logic       strapMeta_q;
  logic       strapSync_q;

  // release the async reset through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rstPipe_q <= 2'b00;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end

  assign rstN = rstPipe_q[1];

  // strap is a pin: two flops, settled before the first hard load
  // a later strap change only takes effect at the next hard reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strapMeta_q <= 1'b0;
      strapSync_q <= 1'b0;
    end
    else
    begin
      strapMeta_q <= strapPin;
      strapSync_q <= strapMeta_q;
    end
  end

  // ---- submodules
  cpad_cfg_if #(.ADDR_W(ADDR_W)) cfg ();

  cpad_base_regs u_base (
    .mclk (mclk),
    .rstN (rstN),
    .ce   (ce),
    .cfg  (cfg)
  );

  cpad_ld_mem #(.ADDR_W(ADDR_W)) u_mem (
    .mclk (mclk),
    .rstN (rstN),
    .ce   (ce),
    .cfg  (cfg)
  );

  // ---- control state
  cpad_state_t state_q,    state_d;
  logic [7:0]  ptr_q,      ptr_d;
  logic        ptrSeen_q,  ptrSeen_d;
  logic [7:0]  ldn_q,      ldn_d;
  logic        initDone_q, initDone_d;
  logic        hardRst;
  logic        softRst;
  logic        hitKey;
  logic        hitValue;
  logic        takeWr;
  logic        takeRd;
  logic        rdPend_q;
  logic [15:0] keyAddr;

  // first cycle after release is the power-on hard load
  // i/o cycles are refused for as long as a hard reset stands
  assign hardRst = !initDone_q || !systemResetOutputN;

  // port decode against the live base
  // upper four address bits must be zero to hit either port
  assign keyAddr  = {4'h0, cfg.decodeBase};
  assign hitKey   = (ioAddr == keyAddr);
  assign hitValue = (ioAddr == keyAddr + VALUE_PORT_OFS);

  // one read outstanding; requests in its shadow are dropped
  // a host must leave one idle cycle after each read request
  assign takeWr = ioWrStb && !rdPend_q && !hardRst;
  assign takeRd = ioRdStb && !rdPend_q && !hardRst;

  // soft reset strobe from the control register
  // it never reaches the base registers, which keep their value
  assign softRst = takeWr && hitValue && (state_q == ST_CONFIG)
                   && (ptr_q == IDX_CFG_CTRL)
                   && ioWrData[SOFT_RST_BIT];

  // hard load of the base registers from the strap
  assign cfg.strap    = strapSync_q;
  assign cfg.hardLoad = ce && hardRst;
  assign cfg.wdata    = ioWrData;

  // base register writes through the value port
  always_comb
  begin
    cfg.wrLow  = 1'b0;
    cfg.wrHigh = 1'b0;
    if (takeWr && hitValue && (state_q == ST_CONFIG))
    begin
      cfg.wrLow  = (ptr_q == IDX_BASE_LOW);
      cfg.wrHigh = (ptr_q == IDX_BASE_HIGH);
    end
  end

  // logical-device storage, addressed by device number and pointer
  // only indexes from 0x30 up write storage; lower ones are globals
  always_comb
  begin
    cfg.memAddr = {ldn_q[LDN_W-1:0], ptr_q};
    cfg.memWe   = takeWr && hitValue && (state_q == ST_CONFIG)
                  && (ptr_q >= IDX_LD_FIRST);
  end

  // next state of the key lock, pointer and device number
  always_comb
  begin
    state_d    = state_q;
    ptr_d      = ptr_q;
    ptrSeen_d  = ptrSeen_q;
    ldn_d      = ldn_q;
    initDone_d = 1'b1;
    if (hardRst)
    begin
      state_d   = ST_RUN;
      ptr_d     = PTR_RST;
      ptrSeen_d = 1'b0;
      ldn_d     = LDN_RST;
    end
    else if (takeWr && hitKey)
    begin
      case (state_q)
        ST_RUN:
        begin
          if (ioWrData == KEY_ENTER)
          begin
            state_d   = ST_CONFIG;
            ptrSeen_d = 1'b0;
          end
        end
        ST_CONFIG:
        begin
          if (ioWrData == KEY_EXIT)
            state_d = ST_RUN;
          else
          begin
            ptr_d     = ioWrData;
            ptrSeen_d = 1'b1;
          end
        end
        default:
          state_d = ST_RUN;
      endcase
    end
    else if (takeWr && hitValue && (state_q == ST_CONFIG))
    begin
      // soft reset touches the device number but not the base
      if (softRst)
        ldn_d = LDN_RST;
      else if (ptr_q == IDX_LDN)
        ldn_d = ioWrData;
    end
  end

  // register the key lock, pointer and device number
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q    <= ST_RUN;
      ptr_q      <= PTR_RST;
      ptrSeen_q  <= 1'b0;
      ldn_q      <= LDN_RST;
      initDone_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q    <= state_d;
      ptr_q      <= ptr_d;
      ptrSeen_q  <= ptrSeen_d;
      ldn_q      <= ldn_d;
      initDone_q <= initDone_d;
    end
  end

  // ---- read path: capture at the request, answer one cycle later
  // a floating answer still pulses valid so the host never stalls
  logic        rdPend_d;
  logic        rdKey_q,   rdKey_d;
  logic        rdDrv_q,   rdDrv_d;
  logic [7:0]  rdIdx_q,   rdIdx_d;
  logic [7:0]  rdKeyVal_q, rdKeyVal_d;
  logic [7:0]  rdData_q,  rdData_d;
  logic        rdValid_q, rdValid_d;
  logic        rdDrive_q, rdDrive_d;
  logic        cfgAct_q;
  logic [7:0]  valueRead;

  // value port read mux, selected by the pointer captured at request
  always_comb
  begin
    case (rdIdx_q)
      IDX_LDN:       valueRead = ldn_q;
      IDX_DEV_ID:    valueRead = DEV_ID;
      IDX_DEV_REV:   valueRead = DEV_REV;
      IDX_BASE_LOW:  valueRead = cfg.baseLow;
      IDX_BASE_HIGH: valueRead = cfg.baseHigh;
      default:
      begin
        // control register is write-only; other globals read zero
        if (rdIdx_q >= IDX_LD_FIRST)
          valueRead = cfg.memRdata;
        else
          valueRead = READ_ZERO;
      end
    endcase
  end

  // read sequencing: capture on the taking edge, answer on the next
  always_comb
  begin
    rdPend_d   = 1'b0;
    rdKey_d    = rdKey_q;
    rdDrv_d    = rdDrv_q;
    rdIdx_d    = rdIdx_q;
    rdKeyVal_d = rdKeyVal_q;
    rdData_d   = rdData_q;
    rdValid_d  = 1'b0;
    rdDrive_d  = 1'b0;
    if (takeRd && (hitKey || hitValue))
    begin
      rdPend_d   = 1'b1;
      rdKey_d    = hitKey;
      rdIdx_d    = ptr_q;
      // both ports only drive their answer inside configuration state
      rdDrv_d    = (state_q == ST_CONFIG);
      rdKeyVal_d = ptrSeen_q ? ptr_q : KEY_READ_NONE;
    end
    else if (rdPend_q)
    begin
      rdValid_d = 1'b1;
      rdDrive_d = rdDrv_q;
      if (!rdDrv_q)
        rdData_d = READ_ZERO;
      else if (rdKey_q)
        rdData_d = rdKeyVal_q;
      else
        rdData_d = valueRead;
    end
  end

  // register the read path; valid and drive last exactly one cycle
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdPend_q   <= 1'b0;
      rdKey_q    <= 1'b0;
      rdDrv_q    <= 1'b0;
      rdIdx_q    <= PTR_RST;
      rdKeyVal_q <= KEY_READ_NONE;
      rdData_q   <= READ_ZERO;
      rdValid_q  <= 1'b0;
      rdDrive_q  <= 1'b0;
      cfgAct_q   <= 1'b0;
    end
    else if (ce)
    begin
      rdPend_q   <= rdPend_d;
      rdKey_q    <= rdKey_d;
      rdDrv_q    <= rdDrv_d;
      rdIdx_q    <= rdIdx_d;
      rdKeyVal_q <= rdKeyVal_d;
      rdData_q   <= rdData_d;
      rdValid_q  <= rdValid_d;
      rdDrive_q  <= rdDrive_d;
      cfgAct_q   <= (state_d == ST_CONFIG);
    end
  end

  // outputs straight from flops
  assign ioRdData  = rdData_q;
  assign ioRdValid = rdValid_q;
  assign ioRdDrive = rdDrive_q;
  assign cfgActive = cfgAct_q;

endmodule : cpad_decoder
`default_nettype wire

// >>> cpad_decoder_sva.sv
// checker: port-level timing properties of the decoder
`timescale 1ns/1ps
`default_nettype none
module cpad_decoder_sva
  import cpad_pkg::*;
(
  // clock and resets
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       ce,
  input wire logic       systemResetOutputN,
  // host i/o port
  input wire logic [7:0] ioWrData,
  input wire logic       ioWrStb,
  input wire logic       ioRdStb,
  input wire logic [7:0] ioRdData,
  input wire logic       ioRdValid,
  input wire logic       ioRdDrive,
  input wire logic       cfgActive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // answers come exactly two edges after the strobe
  a_rd_answer_lat: assert property (
    ioRdValid |-> $past(ioRdStb, 2))
    else $error("read answer without strobe two cycles before");
  // answer stands one cycle, the pending strobe is dropped
  a_rd_one_cycle: assert property (
    ioRdValid |=> !ioRdValid)
    else $error("read answer held longer than one cycle");
  // drive only ever comes with an answer
  a_drive_with_ans: assert property (
    ioRdDrive |-> ioRdValid)
    else $error("drive without read answer");
  // a floating answer carries no data
  a_float_no_data: assert property (
    ioRdValid && !ioRdDrive |-> ioRdData == 8'h00)
    else $error("undriven answer carries data");
  // entry only through the unlock byte
  a_enter_key: assert property (
    $rose(cfgActive) |-> $past(ioWrStb) && ($past(ioWrData) == KEY_ENTER))
    else $error("configuration state entered without unlock");
  // exit only through the lock byte or a hard reset
  a_exit_key: assert property (
    $fell(cfgActive) |->
      ($past(ioWrStb) && ($past(ioWrData) == KEY_EXIT)) ||
      !$past(systemResetOutputN))
    else $error("configuration state left without lock byte");
  // system reset output puts the block back in run state
  a_sysrst_run: assert property (
    !systemResetOutputN && ce |=> !cfgActive)
    else $error("run state not forced by system reset");
  // no answers while hard reset has stood for a while
  a_sysrst_quiet: assert property (
    (!systemResetOutputN) [*3] |-> !ioRdValid)
    else $error("read answered during hard reset");
  // state holds when no write comes in
  a_state_hold: assert property (
    !ioWrStb && systemResetOutputN |=> $stable(cfgActive))
    else $error("state changed without a write");
endmodule : cpad_decoder_sva

bind cpad_decoder cpad_decoder_sva u_cpad_decoder_sva (
  .mclk, .reset_n, .ce, .systemResetOutputN, .ioWrData, .ioWrStb,
  .ioRdStb, .ioRdData, .ioRdValid, .ioRdDrive, .cfgActive);
`default_nettype wire

// >>> cpad_host_model.sv
// host model: issues i/o write and read cycles to the decoder
`timescale 1ns/1ps
`default_nettype none
module cpad_host_model
(
  // clock
  input  wire logic        mclk,
  // i/o cycle port
  output var  logic [15:0] ioAddr,
  output var  logic [7:0]  ioWrData,
  output var  logic        ioWrStb,
  output var  logic        ioRdStb,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        ioRdValid,
  input  wire logic        ioRdDrive
);
  // idle bus at time zero
  initial
  begin
    ioAddr   = 16'h0000;
    ioWrData = 8'h00;
    ioWrStb  = 1'b0;
    ioRdStb  = 1'b0;
  end

  // one-cycle write; released lines show inverted junk, not old data
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    ioAddr   = a;
    ioWrData = d;
    ioWrStb  = 1'b1;
    @(posedge mclk);
    #1;
    ioWrStb  = 1'b0;
    ioAddr   = ~a;
    ioWrData = ~d;
  endtask : wr

  // one-cycle read; waits a bounded time, next request comes later
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v, output logic dr);
    v  = 1'b0;
    d  = 8'h00;
    dr = 1'b0;
    @(posedge mclk);
    #1;
    ioAddr  = a;
    ioRdStb = 1'b1;
    @(posedge mclk);
    #1;
    ioRdStb = 1'b0;
    ioAddr  = ~a;
    repeat (3)
    begin
      @(posedge mclk);
      #1;
      if (ioRdValid === 1'b1 && !v)
      begin
        v  = 1'b1;
        d  = ioRdData;
        dr = ioRdDrive;
      end
    end
  endtask : rd
endmodule : cpad_host_model
`default_nettype wire

// >>> tb_top.sv
// testbench: key, pointer, value and relocation sequences
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cpad_pkg::*;
;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        sysRstN = 1'b1;
  logic        strapPin = 1'b0;
  logic [15:0] ioAddr;
  logic [7:0]  ioWrData;
  logic        ioWrStb;
  logic        ioRdStb;
  logic [7:0]  ioRdData;
  logic        ioRdValid;
  logic        ioRdDrive;
  logic        cfgActive;
  int          fail_count = 0;
  int          comparisons = 0;
  // identity values are arbitrary; set here so the read path is proven
  localparam logic [7:0] TB_DEV_ID  = 8'h3C;
  localparam logic [7:0] TB_DEV_REV = 8'h07;

  // 50 MHz clock
  always #10 mclk = ~mclk;

  cpad_decoder #(.DEV_ID(TB_DEV_ID), .DEV_REV(TB_DEV_REV))
    u_cpad_decoder (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .systemResetOutputN(sysRstN), .strapPin(strapPin), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioRdData(ioRdData), .ioRdValid(ioRdValid), .ioRdDrive(ioRdDrive),
    .cfgActive(cfgActive));

  cpad_host_model u_cpad_host_model (.mclk(mclk), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioRdData(ioRdData), .ioRdValid(ioRdValid), .ioRdDrive(ioRdDrive));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read and compare valid, drive and data (0x00 when floating)
  task automatic rc(input logic [15:0] a, input logic dr,
                    input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    logic       g;
    u_cpad_host_model.rd(a, d, v, g);
    chk("ioRdValid", 8'h01, {7'h00, v});
    chk("ioRdDrive", {7'h00, dr}, {7'h00, g});
    chk("ioRdData", e, d);
  endtask : rc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_cpad_host_model.wr(a, d);
  endtask : wr

  // watchdog far beyond the 180 or so cycles the tests need
  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin : main
    logic [7:0] d;
    logic       v;
    logic       g;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge mclk);
    rc(16'h002E, 1'b0, 8'h00);
    rc(16'h002F, 1'b0, 8'h00);
    wr(16'h002E, KEY_ENTER);
    chk("cfgActive", 8'h01, {7'h00, cfgActive});
    rc(16'h002E, 1'b1, 8'h00);
    wr(16'h002E, IDX_BASE_LOW);
    rc(16'h002E, 1'b1, 8'h26);
    rc(16'h002F, 1'b1, BASE_LOW_RST0);
    wr(16'h002F, 8'h61);
    rc(16'h002F, 1'b1, 8'h60);
    rc(16'h002E, 1'b1, 8'h26);
    wr(16'h002E, IDX_BASE_HIGH);
    rc(16'h002F, 1'b1, BASE_HIGH_RST);
    wr(16'h002F, 8'hF1);
    u_cpad_host_model.rd(16'h002E, d, v, g);
    chk("old port answer", 8'h00, {7'h00, v});
    rc(16'h0161, 1'b1, 8'h01);
    rc(16'h0160, 1'b1, 8'h27);
    wr(16'h0160, IDX_DEV_ID);
    rc(16'h0161, 1'b1, TB_DEV_ID);
    wr(16'h0160, IDX_DEV_REV);
    rc(16'h0161, 1'b1, TB_DEV_REV);
    wr(16'h0160, IDX_LDN);
    wr(16'h0161, 8'h05);
    rc(16'h0161, 1'b1, 8'h05);
    wr(16'h0160, IDX_LD_FIRST);
    wr(16'h0161, 8'h5A);
    rc(16'h0161, 1'b1, 8'h5A);
    wr(16'h0160, IDX_CFG_CTRL);
    wr(16'h0161, 8'h01);
    wr(16'h0160, IDX_LDN);
    rc(16'h0161, 1'b1, LDN_RST);
    wr(16'h0160, IDX_BASE_LOW);
    rc(16'h0161, 1'b1, 8'h60);
    wr(16'h0160, KEY_EXIT);
    chk("cfgActive", 8'h00, {7'h00, cfgActive});
    wr(16'h0161, 8'h33);
    rc(16'h0161, 1'b0, 8'h00);
    // re-enter: the ignored write must not have reached the low byte
    wr(16'h0160, KEY_ENTER);
    rc(16'h0160, 1'b1, 8'h00);
    rc(16'h0161, 1'b1, 8'h60);
    // hard reset inside configuration state, strap high and settled
    strapPin = 1'b1;
    repeat (3) @(posedge mclk);
    #1 sysRstN = 1'b0;
    repeat (3) @(posedge mclk);
    #1 sysRstN = 1'b1;
    repeat (5) @(posedge mclk);
    u_cpad_host_model.rd(16'h0160, d, v, g);
    chk("relocated port answer", 8'h00, {7'h00, v});
    chk("cfgActive", 8'h00, {7'h00, cfgActive});
    rc(16'h004E, 1'b0, 8'h00);
    wr(16'h004E, KEY_ENTER);
    chk("cfgActive", 8'h01, {7'h00, cfgActive});
    wr(16'h004E, IDX_BASE_LOW);
    rc(16'h004F, 1'b1, BASE_LOW_RST1);
    wr(16'h004E, IDX_BASE_HIGH);
    rc(16'h004F, 1'b1, BASE_HIGH_RST);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
